/* File: design/wake_timer_pkg.sv */
package wake_timer_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_PERIOD_HI   = 6'h1E;
  localparam logic [5:0] ADDR_PERIOD_LO   = 6'h1F;
  localparam logic [5:0] ADDR_CONTROL     = 6'h20;
  localparam logic [5:0] ADDR_READOUT_HI  = 6'h38;
  localparam logic [5:0] ADDR_READOUT_LO  = 6'h39;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] PERIOD_HI_RESET  = 8'h87;
  localparam logic [7:0] PERIOD_LO_RESET  = 8'h6B;
  localparam logic       PD_RESET         = 1'b1;
  localparam logic [2:0] EV1_SEL_RESET    = 3'h7;
  localparam logic       CAL_EN_RESET     = 1'b1;
  localparam logic [1:0] RES_RESET        = 2'h0;
  localparam int         CTRL_PD_BIT      = 7;
  localparam int         CTRL_EV1_MSB     = 6;
  localparam int         CTRL_EV1_LSB     = 4;
  localparam int         CTRL_CAL_BIT     = 3;
  localparam int         CTRL_RES_MSB     = 1;
  localparam int         CTRL_RES_LSB     = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Crystal clocks per slow oscillator period
  localparam int         RC_DIVIDE        = 750;
  localparam int         RC_CNT_W         = 10;
  // Slow periods spent in the start-up calibration
  localparam int         CAL_PERIODS_DEF  = 4;
  // Last step count for each resolution: 1, 2^5, 2^10, 2^15 periods
  localparam logic [14:0] STEP_LAST_RES0  = 15'h0000;
  localparam logic [14:0] STEP_LAST_RES1  = 15'h001F;
  localparam logic [14:0] STEP_LAST_RES2  = 15'h03FF;
  localparam logic [14:0] STEP_LAST_RES3  = 15'h7FFF;

  // Second event delay in slow periods, four times longer with autosync on
  function automatic logic [7:0] ev1_delay(input logic [2:0] sel, input logic autosync);
    logic [7:0] base;
    base = 8'h00;
    unique case (sel)
      3'h0: base = 8'h04;
      3'h1: base = 8'h06;
      3'h2: base = 8'h08;
      3'h3: base = 8'h0C;
      3'h4: base = 8'h10;
      3'h5: base = 8'h18;
      3'h6: base = 8'h20;
      3'h7: base = 8'h30;
    endcase
    return autosync ? {base[5:0], 2'b00} : base;
  endfunction

endpackage

/* File: design/slow_osc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface slow_osc_if;
  logic run;
  logic tick;
  modport ctrl (output run, input tick);
  modport osc  (input run, output tick);
endinterface
`default_nettype wire

/* File: design/slow_osc_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module slow_osc_divider
  import wake_timer_pkg::*;
#(
  parameter int DIVIDE = RC_DIVIDE
) (
  input  wire logic  clk,
  input  wire logic  rst,
  slow_osc_if.osc    osc
);

  generate
    if (DIVIDE < 2 || DIVIDE > (1 << RC_CNT_W)) begin : g_bad_div
      $error("divider value out of range");
    end
  endgenerate

  localparam logic [RC_CNT_W-1:0] CNT_LAST = RC_CNT_W'(DIVIDE - 1);

  typedef struct packed {
    logic [RC_CNT_W-1:0] cnt;
    logic                tick;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  // ----------------------------------------------------------------
  // Divide crystal clock down to slow oscillator periods
  // ----------------------------------------------------------------
  // Counter holds at zero while powered down
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!osc.run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == CNT_LAST) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign osc.tick = st_r.tick;

  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    st_r.tick |-> $past(st_r.cnt) == CNT_LAST && $past(osc.run))
    else $error("slow tick not after full divide");

endmodule
`default_nettype wire

/* File: design/wake_radio_event_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module wake_radio_event_timer
  import wake_timer_pkg::*;
#(
  parameter int CAL_PERIODS = CAL_PERIODS_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       wake_autosync_select,
  output logic            wake_period_value_pulse,
  output logic            second_event_delay_select_pulse,
  output logic            slow_osc_running,
  output logic            slow_osc_cal_active
);

  generate
    if (CAL_PERIODS < 1 || CAL_PERIODS > 15) begin : g_bad_cal
      $error("calibration length out of range");
    end
  endgenerate

  localparam logic [3:0] CAL_LOAD = 4'(CAL_PERIODS);

  typedef struct packed {
    logic [7:0]  period_hi;
    logic [7:0]  period_lo;
    logic        pd;
    logic [2:0]  ev1_sel;
    logic        cal_en;
    logic [1:0]  res;
    logic [14:0] step_cnt;
    logic [15:0] period_cnt;
    logic [7:0]  ev1_cnt;
    logic [15:0] readout;
    logic [3:0]  cal_cnt;
    logic        ev0;
    logic        ev1;
    logic [7:0]  rdata;
  } timer_state_t;

  timer_state_t st_r;
  timer_state_t st_nxt;
  slow_osc_if   osc ();

  // ----------------------------------------------------------------
  // Slow oscillator
  // ----------------------------------------------------------------
  // divided slow clock
  slow_osc_divider #(.DIVIDE(RC_DIVIDE)) u_div (
    .clk (clk),
    .rst (rst),
    .osc (osc)
  );

  assign osc.run = !st_r.pd;

  // ----------------------------------------------------------------
  // Derived terms
  // ----------------------------------------------------------------
  logic [15:0] period_val;
  logic [14:0] step_last;
  logic        step_done;
  logic        period_done;
  logic        ctrl_wr;

  assign period_val = {st_r.period_hi, st_r.period_lo};
  assign ctrl_wr    = reg_wr_en && reg_addr == ADDR_CONTROL;

  always_comb begin
    step_last = STEP_LAST_RES0;
    unique case (st_r.res)
      2'h0: step_last = STEP_LAST_RES0;
      2'h1: step_last = STEP_LAST_RES1;
      2'h2: step_last = STEP_LAST_RES2;
      2'h3: step_last = STEP_LAST_RES3;
    endcase
  end

  // A value of zero behaves as one step
  // At or above the last count, so a lowered resolution cannot strand the step count
  assign step_done   = osc.tick && st_r.step_cnt >= step_last;
  assign period_done = step_done && ({1'b0, st_r.period_cnt} + 17'h00001) >= {1'b0, period_val};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ev0 = 1'b0;
    st_nxt.ev1 = 1'b0;

    if (step_done) begin
      st_nxt.step_cnt   = '0;
      st_nxt.period_cnt = st_r.period_cnt + 1'b1;
    end else if (osc.tick) begin
      st_nxt.step_cnt = st_r.step_cnt + 1'b1;
    end

    if (osc.tick) begin
      st_nxt.readout = st_r.readout + 1'b1;
    end

    if (osc.tick && st_r.ev1_cnt != 8'h00) begin
      st_nxt.ev1_cnt = st_r.ev1_cnt - 1'b1;
      st_nxt.ev1     = st_r.ev1_cnt == 8'h01;
    end

    if (period_done) begin
      st_nxt.ev0        = 1'b1;
      st_nxt.period_cnt = '0;
      st_nxt.readout    = '0;
      st_nxt.ev1_cnt    = ev1_delay(st_r.ev1_sel, wake_autosync_select);
    end

    // Calibration runs on slow periods
    if (osc.tick && st_r.cal_cnt != 4'h0) begin
      st_nxt.cal_cnt = st_r.cal_cnt - 1'b1;
    end

    if (reg_wr_en && reg_addr == ADDR_PERIOD_HI) begin
      st_nxt.period_hi = reg_wdata;
    end
    if (reg_wr_en && reg_addr == ADDR_PERIOD_LO) begin
      st_nxt.period_lo = reg_wdata;
    end

    // Control register write
    if (ctrl_wr) begin
      st_nxt.pd      = reg_wdata[CTRL_PD_BIT];
      st_nxt.ev1_sel = reg_wdata[CTRL_EV1_MSB:CTRL_EV1_LSB];
      st_nxt.cal_en  = reg_wdata[CTRL_CAL_BIT];
      st_nxt.res     = reg_wdata[CTRL_RES_MSB:CTRL_RES_LSB];
      if (!reg_wdata[CTRL_CAL_BIT]) begin
        st_nxt.cal_cnt = 4'h0;
      end else if (!reg_wdata[CTRL_PD_BIT]) begin
        st_nxt.cal_cnt = CAL_LOAD;
      end
    end

    // Registered read data, reserved bit 2 reads zero
    if (reg_rd_en) begin
      unique case (reg_addr)
        ADDR_PERIOD_HI:  st_nxt.rdata = st_r.period_hi;
        ADDR_PERIOD_LO:  st_nxt.rdata = st_r.period_lo;
        ADDR_CONTROL:    st_nxt.rdata = {st_r.pd, st_r.ev1_sel, st_r.cal_en, 1'b0, st_r.res};
        ADDR_READOUT_HI: st_nxt.rdata = st_r.readout[15:8];
        ADDR_READOUT_LO: st_nxt.rdata = st_r.readout[7:0];
        default:         st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // documented reset values
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r           <= '0;
      st_r.period_hi <= PERIOD_HI_RESET;
      st_r.period_lo <= PERIOD_LO_RESET;
      st_r.pd        <= PD_RESET;
      st_r.ev1_sel   <= EV1_SEL_RESET;
      st_r.cal_en    <= CAL_EN_RESET;
      st_r.res       <= RES_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata           = st_r.rdata;
  assign wake_period_value_pulse        = st_r.ev0;
  assign second_event_delay_select_pulse        = st_r.ev1;
  assign slow_osc_running    = !st_r.pd;
  assign slow_osc_cal_active = st_r.cal_cnt != 4'h0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_wake_period_value_moment: assert property (
    osc.tick && st_r.step_cnt == step_last
      && {1'b0, st_r.period_cnt} + 17'h00001 >= {1'b0, period_val} |=> wake_period_value_pulse)
    else $error("Event 0 missed at period end");

  a_period_write: assert property (
    reg_wr_en && reg_addr == ADDR_PERIOD_LO |=> st_r.period_lo == $past(reg_wdata))
    else $error("period low byte not stored");

  a_reset_values: assert property (
    $fell(rst) |-> period_val == {PERIOD_HI_RESET, PERIOD_LO_RESET}
      && st_r.ev1_sel == EV1_SEL_RESET && st_r.pd && st_r.cal_en)
    else $error("wrong reset values");

  a_pd_stops_osc: assert property (
    st_r.pd && $past(st_r.pd) |-> !osc.tick ##1 !osc.tick)
    else $error("slow tick while powered down");

  a_cal_starts: assert property (
    ctrl_wr && !reg_wdata[CTRL_PD_BIT] && reg_wdata[CTRL_CAL_BIT]
      |=> slow_osc_cal_active && st_r.cal_cnt == CAL_LOAD)
    else $error("calibration did not start");

  a_second_event_delay_select_load: assert property (
    wake_period_value_pulse |-> st_r.ev1_cnt == ev1_delay($past(st_r.ev1_sel), $past(wake_autosync_select)))
    else $error("wrong second event delay");

  a_second_event_delay_select_fire: assert property (
    osc.tick && st_r.ev1_cnt == 8'h01 |=> second_event_delay_select_pulse)
    else $error("Event 1 missed");

  a_cal_disable: assert property (
    ctrl_wr && !reg_wdata[CTRL_CAL_BIT] |=> !slow_osc_cal_active)
    else $error("calibration active while disabled");

  a_step_count: assert property (
    osc.tick && st_r.step_cnt < step_last |=> st_r.step_cnt == $past(st_r.step_cnt) + 15'h0001)
    else $error("step counter slipped");

  a_readout_rate: assert property (
    osc.tick |=> st_r.readout == $past(st_r.readout) + 16'h0001 || wake_period_value_pulse)
    else $error("readout not one per slow period");

  a_restart: assert property (
    wake_period_value_pulse |-> st_r.period_cnt == 16'h0000 && st_r.step_cnt == 15'h0000)
    else $error("timer not restarted after Event 0");

  c_wake_period_value:      cover property (wake_period_value_pulse);
  c_second_event_delay_select:      cover property (second_event_delay_select_pulse);
  c_calibration: cover property ($fell(slow_osc_cal_active));
  c_autosync:    cover property (wake_period_value_pulse && wake_autosync_select);

endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wake_timer_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk;
  logic       rst;
  logic       reg_wr_en;
  logic       reg_rd_en;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       wake_autosync_select;
  logic       wake_period_value_pulse;
  logic       second_event_delay_select_pulse;
  logic       slow_osc_running;
  logic       slow_osc_cal_active;
  int         err_total;
  int         cmp_count;

  // Calibration shortened to one slow period
  wake_radio_event_timer #(
    .CAL_PERIODS (1)
  ) dut (
    .clk                  (clk),
    .rst                  (rst),
    .reg_wr_en            (reg_wr_en),
    .reg_rd_en            (reg_rd_en),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .wake_autosync_select (wake_autosync_select),
    .wake_period_value_pulse         (wake_period_value_pulse),
    .second_event_delay_select_pulse         (second_event_delay_select_pulse),
    .slow_osc_running     (slow_osc_running),
    .slow_osc_cal_active  (slow_osc_cal_active)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare one value and count it
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One register write, strobe held for one edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  // One register read, data taken after the strobe edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge clk);
    reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask

  // Cycles until the next wake event
  task automatic wait_ev0(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wake_period_value_pulse !== 1'b1 && n < 100000);
  endtask

  // From one wake event: cycles to the second event and to the next wake
  task automatic measure(output int t1, output int t0);
    t1 = 0;
    t0 = 0;
    do begin
      @(negedge clk);
      t0++;
      if (second_event_delay_select_pulse === 1'b1 && t1 == 0) begin
        t1 = t0;
      end
    end while (wake_period_value_pulse !== 1'b1 && t0 < 100000);
  endtask

  // Expected second event delay in slow periods
  function automatic int exp_delay(input logic [2:0] s, input logic a);
    int t[8] = '{4, 6, 8, 12, 16, 24, 32, 48};
    return a ? 4 * t[s] : t[s];
  endfunction

  // ----------------------------------------------------------------
  // Clock, watchdog
  // ----------------------------------------------------------------
  // 20 MHz crystal clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cut a hang short; the longest legal run is about 70000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] h;
    logic [7:0] l;
    logic [7:0] c;
    int         n;
    int         t1;
    int         t0;
    int         cur;
    logic [2:0] s;
    logic       a;
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    wake_autosync_select = 1'b0;
    void'($urandom(32'hE9AF));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    // Reset values and stopped oscillator
    rd(ADDR_PERIOD_HI, d);
    chk(d, 16'h0087);
    rd(ADDR_PERIOD_LO, d);
    chk(d, 16'h006B);
    rd(ADDR_CONTROL, d);
    chk(d, 16'h00F8);
    chk(slow_osc_running, 1'b0);
    // Unmapped place: reads zero, write has no effect
    n = $urandom % 30;
    wr(6'(n), 8'($urandom));
    rd(6'(n), d);
    chk(d, 16'h0000);
    rd(ADDR_PERIOD_HI, d);
    chk(d, 16'h0087);
    // Random read-back of the period bytes and control while powered down
    repeat (6) begin
      h = 8'($urandom);
      l = 8'($urandom);
      c = 8'($urandom) | 8'h80;
      wr(ADDR_PERIOD_HI, h);
      wr(ADDR_PERIOD_LO, l);
      wr(ADDR_CONTROL, c);
      rd(ADDR_PERIOD_HI, d);
      chk(d, h);
      rd(ADDR_PERIOD_LO, d);
      chk(d, l);
      rd(ADDR_CONTROL, d);
      chk(d, c & 8'hFB);
      chk(slow_osc_running, 1'b0);
    end
    // Power up with calibration, one-step period
    wr(ADDR_PERIOD_HI, 8'h00);
    wr(ADDR_PERIOD_LO, 8'h01);
    wr(ADDR_CONTROL, 8'h08);
    chk({slow_osc_running, slow_osc_cal_active}, 2'b11);
    wait_ev0(n);
    chk(n >= 750 && n <= 753, 1'b1);
    chk(slow_osc_cal_active, 1'b0);
    measure(t1, t0);
    chk(16'(t0), 16'd750);
    // Second event delay: the code for the next period is set while the
    // current one runs; the two writes take four cycles off each count
    cur = exp_delay(3'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      s = (i == 1) ? 3'h0 : 3'($urandom % 5);
      a = (i == 1);
      wake_autosync_select = a;
      wr(ADDR_PERIOD_LO, 8'(cur + 1));
      wr(ADDR_CONTROL, {1'b0, s, 4'h0});
      chk(slow_osc_cal_active, 1'b0);
      measure(t1, t0);
      chk(16'(t1), 16'(cur * 750 - 4));
      chk(16'(t0), 16'((cur + 1) * 750 - 4));
      cur = exp_delay(s, a);
    end
    // Coarser resolution; readout keeps counting plain slow periods
    wake_autosync_select = 1'b0;
    wr(ADDR_PERIOD_LO, 8'h01);
    wr(ADDR_CONTROL, 8'h01);
    repeat (3756) @(negedge clk);
    rd(ADDR_READOUT_LO, d);
    chk(d, 16'h0005);
    rd(ADDR_READOUT_HI, d);
    chk(d, 16'h0000);
    wait_ev0(n);
    chk(16'(n + 3764), 16'd24000);
    // Power down: no further wake events
    wr(ADDR_CONTROL, 8'hF8);
    chk(slow_osc_running, 1'b0);
    t0 = 0;
    repeat (1600) begin
      @(negedge clk);
      if (wake_period_value_pulse !== 1'b0) begin
        t0++;
      end
    end
    chk(16'(t0), 16'h0000);
    complete_run();
  end

endmodule
`default_nettype wire
